// ---- rtl/irc_map.svh ----
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

// =====================================================
// register-file addresses (7-bit)
`define IRC_RF_GATE_NEXT 7'h11
`define IRC_RF_GATE_LIVE 7'h12
`define IRC_RF_TMR_CTL 7'h33
`define IRC_RF_MATCH_FLAG 7'h3F

// =====================================================
// timer control bit positions
`define IRC_CTL_RUN 3
`define IRC_CTL_CLEAR 2
`define IRC_CTL_SEL_HI 1
`define IRC_CTL_SEL_LO 0
`define IRC_FLAG_BIT 0
`define IRC_GATE_BIT 0

// =====================================================
// peripheral register selects on the transfer buffer
`define IRC_PER_COUNT 2'h0
`define IRC_PER_MATCH 2'h1
`define IRC_PER_LOW 2'h2
`define IRC_PER_HIGH 2'h3

// =====================================================
// clock select codes
`define IRC_SEL_DIV32 2'h0
`define IRC_SEL_DIV64 2'h1
`define IRC_SEL_DIV256 2'h2
`define IRC_SEL_CARRIER 2'h3

// =====================================================
// prescaler terminal values and carrier fields
`define IRC_DIV32_MASK 8'h1F
`define IRC_DIV64_MASK 8'h3F
`define IRC_DIV256_MASK 8'hFF
`define IRC_LOW_STEADY_BIT 7
`define IRC_RST_BYTE 8'h00
`define IRC_RST_NIB 4'h0
`define IRC_RST_CNT7 7'h00

`endif

// ---- rtl/irc_pkg.sv ----
// =====================================================
// shared types
package irc_pkg;
   // carrier phase, gray along idle -> high -> low -> high
   typedef enum logic [1:0] {
      IRC_PH_IDLE = 2'b00,
      IRC_PH_HIGH = 2'b01,
      IRC_PH_LOW = 2'b11
   } irc_phase_t;
   typedef logic [1:0] irc_sel_t;
endpackage

// ---- rtl/irc_timer.sv ----
// How it works
// - timer is 8-bit up counter, match register, comparator and clock selector.
// - control at 33H: run bit 3, clear bit 2, clock select bits 1..0.
// - clock select picks system clock over 32, 64, 256 or carrier output.
// - count readable through transfer buffer; writes never change it.
// - match value written through transfer buffer, never readable.
// - count equal to a nonzero match value sets match flag at 3FH bit 0.
// - clear bit is write-only; writing it zeroes the count, reads zero.
// - carrier 7-bit counter is clocked by system clock divided by two.
// - each carrier phase lasts programmed value plus one counter clock.
// - both carrier period registers are writable and readable by software.
// - low-period bit 7 high replaces carrier with steady high level.
// - live gate 1 lets pin follow carrier; gate 0 drives pin low.
// - each timer match copies buffered gate bit into live gate bit.
// - gate closing is deferred while effective gate and carrier are high.
// - carrier stops with gate 0 unless it is the timer clock source.
// - carrier-clocked timer: buffered gate load starts with one low phase.
// - buffered gate bit lives at 11H, live gate bit at 12H.
`include "irc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module irc_timer
   import irc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [6:0] rf_addr_i,
   input wire logic rf_wr_i,
   input wire logic [3:0] rf_wdata_i,
   output logic [3:0] rf_rdata_o,
   input wire logic [1:0] per_sel_i,
   input wire logic per_put_i,
   input wire logic per_get_i,
   input wire logic [7:0] dbf_wdata_i,
   output logic [7:0] dbf_rdata_o,
   input wire logic stop_mode_i,
   output logic timer_match_flag_o,
   output logic ir_carrier_pin_o
);

   // =====================================================
   // helpers
   function automatic logic rf_hit(input logic [6:0] a, input logic [6:0] r);
      rf_hit = (a == r);
   endfunction

   // prescaler terminal test shared by the three divided clocks
   function automatic logic presc_end(input logic [7:0] p, input logic [7:0] m);
      presc_end = ((p & m) == m);
   endfunction

   // =====================================================
   // state
   logic timer_run_q;
   irc_sel_t clk_sel_q;
   logic [7:0] timer_count_value_q;
   logic [7:0] timer_match_value_q;
   logic [7:0] carrier_low_period_q;
   logic [7:0] carrier_high_period_q;
   logic timer_match_flag_q;
   logic carrier_gate_next_q;
   logic gate_live_q;
   logic gate_eff_q;
   logic [7:0] presc_q;
   logic half_q;
   logic [6:0] car_cnt_q;
   irc_phase_t phase_q;
   logic match_evt_q;
   logic [3:0] rf_rdata_q;
   logic [7:0] dbf_rdata_q;
   logic pin_q;

   logic wr_ctl;
   logic wr_flag;
   logic wr_live;
   logic car_run;
   logic car_rise;
   logic [6:0] car_limit;
   logic car_end;
   logic carrier_hi;
   logic timer_tick;
   logic at_match;
   logic gate_load_rise;
   logic src_level;
   logic [7:0] count_d;

   assign wr_ctl = rf_wr_i && rf_hit(rf_addr_i, `IRC_RF_TMR_CTL);
   assign wr_flag = rf_wr_i && rf_hit(rf_addr_i, `IRC_RF_MATCH_FLAG);
   assign wr_live = rf_wr_i && rf_hit(rf_addr_i, `IRC_RF_GATE_LIVE);

   // =====================================================
   // control register: run and clock select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_run_q <= 1'b0;
         clk_sel_q <= `IRC_SEL_DIV32;
      end else begin
         if (wr_ctl) begin
            timer_run_q <= rf_wdata_i[`IRC_CTL_RUN];
            clk_sel_q <= rf_wdata_i[`IRC_CTL_SEL_HI:`IRC_CTL_SEL_LO];
         end
         // stop mode drops run; software re-arms it afterwards
         if (stop_mode_i) begin
            timer_run_q <= 1'b0;
         end
      end
   end

   // =====================================================
   // prescaler and divide-by-two carrier clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_q <= `IRC_RST_BYTE;
         half_q <= 1'b0;
      end else begin
         presc_q <= presc_q + 8'h01;
         half_q <= ~half_q;
      end
   end

   // =====================================================
   // carrier generator
   // keeps running as timer clock source even with the gate closed
   assign car_run = gate_live_q || gate_eff_q || (clk_sel_q == `IRC_SEL_CARRIER);
   assign car_limit = (phase_q == IRC_PH_HIGH) ? carrier_high_period_q[6:0]
                                               : carrier_low_period_q[6:0];
   assign car_end = half_q && (car_cnt_q >= car_limit);
   assign carrier_hi = (phase_q == IRC_PH_HIGH);
   assign car_rise = car_end && (phase_q == IRC_PH_LOW);
   // buffered load of an open gate while the carrier times the counter
   assign gate_load_rise = match_evt_q && carrier_gate_next_q && !gate_live_q
                           && (clk_sel_q == `IRC_SEL_CARRIER);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= IRC_PH_IDLE;
         car_cnt_q <= `IRC_RST_CNT7;
      end else if (!car_run) begin
         phase_q <= IRC_PH_IDLE;
         car_cnt_q <= `IRC_RST_CNT7;
      end else if (gate_load_rise) begin
         phase_q <= IRC_PH_LOW;
         car_cnt_q <= `IRC_RST_CNT7;
      end else begin
         unique case (phase_q)
            IRC_PH_IDLE: begin
               // restart with a full high phase
               phase_q <= IRC_PH_HIGH;
               car_cnt_q <= `IRC_RST_CNT7;
            end
            IRC_PH_HIGH: begin
               if (car_end) begin
                  phase_q <= IRC_PH_LOW;
                  car_cnt_q <= `IRC_RST_CNT7;
               end else if (half_q) begin
                  car_cnt_q <= car_cnt_q + 7'h01;
               end
            end
            IRC_PH_LOW: begin
               if (car_end) begin
                  phase_q <= IRC_PH_HIGH;
                  car_cnt_q <= `IRC_RST_CNT7;
               end else if (half_q) begin
                  car_cnt_q <= car_cnt_q + 7'h01;
               end
            end
            default: begin
               phase_q <= IRC_PH_IDLE;
               car_cnt_q <= `IRC_RST_CNT7;
            end
         endcase
      end
   end

   // =====================================================
   // timer clock select and counting
   always_comb begin
      unique case (clk_sel_q)
         `IRC_SEL_DIV32: timer_tick = presc_end(presc_q, `IRC_DIV32_MASK);
         `IRC_SEL_DIV64: timer_tick = presc_end(presc_q, `IRC_DIV64_MASK);
         `IRC_SEL_DIV256: timer_tick = presc_end(presc_q, `IRC_DIV256_MASK);
         `IRC_SEL_CARRIER: timer_tick = car_rise;
      endcase
   end

   // comparator between count and match value
   assign at_match = (timer_count_value_q == timer_match_value_q);
   assign count_d = at_match ? `IRC_RST_BYTE : timer_count_value_q + 8'h01;

   // no path from the transfer buffer into the count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_count_value_q <= `IRC_RST_BYTE;
         match_evt_q <= 1'b0;
      end else begin
         match_evt_q <= 1'b0;
         if (wr_ctl && rf_wdata_i[`IRC_CTL_CLEAR]) begin
            timer_count_value_q <= `IRC_RST_BYTE;
         end else if (timer_run_q && timer_tick) begin
            timer_count_value_q <= count_d;
            // a zero match value never raises the event
            match_evt_q <= (count_d == timer_match_value_q)
                           && (timer_match_value_q != `IRC_RST_BYTE);
         end
      end
   end

   // =====================================================
   // match flag: hardware set beats a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_match_flag_q <= 1'b0;
      end else if (match_evt_q) begin
         timer_match_flag_q <= 1'b1;
      end else if (wr_flag) begin
         timer_match_flag_q <= rf_wdata_i[`IRC_FLAG_BIT];
      end
   end

   // =====================================================
   // peripheral registers behind the transfer buffer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_match_value_q <= `IRC_RST_BYTE;
         carrier_low_period_q <= `IRC_RST_BYTE;
         carrier_high_period_q <= `IRC_RST_BYTE;
      end else if (per_put_i) begin
         unique case (per_sel_i)
            `IRC_PER_COUNT: ;
            `IRC_PER_MATCH: timer_match_value_q <= dbf_wdata_i;
            `IRC_PER_LOW: carrier_low_period_q <= dbf_wdata_i;
            `IRC_PER_HIGH: carrier_high_period_q <= dbf_wdata_i;
         endcase
      end
   end

   // read data; match value reads as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dbf_rdata_q <= `IRC_RST_BYTE;
      end else if (per_get_i) begin
         unique case (per_sel_i)
            `IRC_PER_COUNT: dbf_rdata_q <= timer_count_value_q;
            `IRC_PER_MATCH: dbf_rdata_q <= `IRC_RST_BYTE;
            `IRC_PER_LOW: dbf_rdata_q <= carrier_low_period_q;
            `IRC_PER_HIGH: dbf_rdata_q <= carrier_high_period_q;
         endcase
      end
   end

   // =====================================================
   // gate bits: buffered and live
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carrier_gate_next_q <= 1'b0;
      end else if (rf_wr_i && rf_hit(rf_addr_i, `IRC_RF_GATE_NEXT)) begin
         carrier_gate_next_q <= rf_wdata_i[`IRC_GATE_BIT];
      end
   end

   // the match transfer wins over a software write in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_live_q <= 1'b0;
      end else if (match_evt_q) begin
         gate_live_q <= carrier_gate_next_q;
      end else if (wr_live) begin
         gate_live_q <= rf_wdata_i[`IRC_GATE_BIT];
      end
   end

   // =====================================================
   // output stage
   assign src_level = carrier_low_period_q[`IRC_LOW_STEADY_BIT] ? 1'b1 : carrier_hi;

   // deferring the gate keeps the last high pulse full width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_eff_q <= 1'b0;
      end else if (!(gate_eff_q && carrier_hi && !gate_live_q)) begin
         gate_eff_q <= gate_live_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= gate_eff_q && src_level;
      end
   end

   // =====================================================
   // register-file read port, one cycle behind the address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rf_rdata_q <= `IRC_RST_NIB;
      end else begin
         rf_rdata_q <= `IRC_RST_NIB;
         if (rf_hit(rf_addr_i, `IRC_RF_TMR_CTL)) begin
            rf_rdata_q <= {timer_run_q, 1'b0, clk_sel_q};
         end else if (rf_hit(rf_addr_i, `IRC_RF_MATCH_FLAG)) begin
            rf_rdata_q <= {3'h0, timer_match_flag_q};
         end else if (rf_hit(rf_addr_i, `IRC_RF_GATE_NEXT)) begin
            rf_rdata_q <= {3'h0, carrier_gate_next_q};
         end else if (rf_hit(rf_addr_i, `IRC_RF_GATE_LIVE)) begin
            rf_rdata_q <= {3'h0, gate_live_q};
         end
      end
   end

   assign rf_rdata_o = rf_rdata_q;
   assign dbf_rdata_o = dbf_rdata_q;
   assign timer_match_flag_o = timer_match_flag_q;
   assign ir_carrier_pin_o = pin_q;

   // =====================================================
   // checks
   sequence s_clear_write;
      wr_ctl && rf_wdata_i[`IRC_CTL_CLEAR];
   endsequence

   sequence s_match_then_copy;
      match_evt_q ##1 1'b1;
   endsequence

   AST_CLEAR_ZEROES: assert property (@(posedge clk_i) disable iff (rst_i)
      s_clear_write |=> (timer_count_value_q == 8'h00))
      else $error("clear write left count nonzero");
   AST_PUT_NO_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
      (per_put_i && per_sel_i == `IRC_PER_COUNT && !timer_tick && !wr_ctl)
      |=> $stable(timer_count_value_q))
      else $error("count changed by a put");
   AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      match_evt_q |=> timer_match_flag_q)
      else $error("match event did not set flag");
   AST_GATE_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
      s_match_then_copy |-> (gate_live_q == $past(carrier_gate_next_q)))
      else $error("live gate not loaded on match");
   AST_ZERO_NO_EVT: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_match_value_q == 8'h00) |=> !match_evt_q)
      else $error("event raised with zero match value");
   AST_PIN_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      (!gate_live_q && !pin_q) [*2] |=> !pin_q)
      else $error("pin high with gate closed");
   AST_STEADY_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_eff_q && carrier_low_period_q[`IRC_LOW_STEADY_BIT]) |=> pin_q)
      else $error("steady high not driven");
   AST_PHASE_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
      (car_run && phase_q != IRC_PH_IDLE) |-> (car_cnt_q <= car_limit))
      else $error("carrier counter passed its limit");
   AST_CAR_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      !car_run |=> (phase_q == IRC_PH_IDLE) && (car_cnt_q == 7'h00))
      else $error("carrier kept running while stopped");
   AST_DEFER_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (gate_eff_q && !gate_live_q && carrier_hi && !car_end && !match_evt_q)
      |=> (gate_eff_q && carrier_hi))
      else $error("closing gate cut a carrier high pulse");
   AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_run_q && timer_tick && at_match && !wr_ctl) |=> (timer_count_value_q == 8'h00))
      else $error("count did not wrap after match");

endmodule

`default_nettype wire

// ---- testbench/ir_carrier_timer_tb.sv ----
`include "irc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ir_carrier_timer_tb;
   import irc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [6:0] rf_addr_i = 7'h00;
   logic rf_wr_i = 1'b0;
   logic [3:0] rf_wdata_i = 4'h0;
   logic [3:0] rf_rdata_o;
   logic [1:0] per_sel_i = 2'h0;
   logic per_put_i = 1'b0;
   logic per_get_i = 1'b0;
   logic [7:0] dbf_wdata_i = 8'h00;
   logic [7:0] dbf_rdata_o;
   logic stop_mode_i = 1'b0;
   logic timer_match_flag_o;
   logic ir_carrier_pin_o;
   logic rd_req = 1'b0;
   logic rd_src = 1'b0;
   logic p1_q = 1'b0;
   logic p1_src_q = 1'b0;
   logic [15:0] exp_q[$];
   string name_q[$];
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int hi_len;
   int lo_len;
   int t0;
   int t1;
   int divs[4] = '{32, 64, 256, 10};
   logic [7:0] r1;
   logic [7:0] r2;

   irc_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .rf_addr_i(rf_addr_i), .rf_wr_i(rf_wr_i),
      .rf_wdata_i(rf_wdata_i), .rf_rdata_o(rf_rdata_o), .per_sel_i(per_sel_i),
      .per_put_i(per_put_i), .per_get_i(per_get_i), .dbf_wdata_i(dbf_wdata_i),
      .dbf_rdata_o(dbf_rdata_o), .stop_mode_i(stop_mode_i),
      .timer_match_flag_o(timer_match_flag_o), .ir_carrier_pin_o(ir_carrier_pin_o));
   irc_led_model u_led (.clk_i(clk_i), .pin_i(ir_carrier_pin_o), .hi_len_o(hi_len),
      .lo_len_o(lo_len));

   // =====================================================
   // clock and cycle count
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   // =====================================================
   // checking
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] e);
      cmp_count++;
      if (seen !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, seen);
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // read results land two edges after the request; oldest note is compared
   always @(posedge clk_i) begin
      if (p1_q) begin
         chk(name_q.pop_front(), p1_src_q ? {8'h00, dbf_rdata_o} : {12'h000, rf_rdata_o},
            exp_q.pop_front());
      end
      p1_q <= rd_req;
      p1_src_q <= rd_src;
   end

   // =====================================================
   // bus tasks, request held across the sampling edge
   task automatic rf_wr(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk_i);
      rf_addr_i <= a;
      rf_wdata_i <= d;
      rf_wr_i <= 1'b1;
      @(posedge clk_i);
      rf_wr_i <= 1'b0;
   endtask

   task automatic put(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk_i);
      per_sel_i <= s;
      dbf_wdata_i <= d;
      per_put_i <= 1'b1;
      @(posedge clk_i);
      per_put_i <= 1'b0;
   endtask

   // src 1 is a transfer-buffer get with select in a[1:0]
   task automatic rd(input logic src, input logic [6:0] a, input logic [7:0] e, input string n);
      @(posedge clk_i);
      if (src) begin
         per_sel_i <= a[1:0];
         per_get_i <= 1'b1;
      end else begin
         rf_addr_i <= a;
      end
      exp_q.push_back({8'h00, e});
      name_q.push_back(n);
      rd_req <= 1'b1;
      rd_src <= src;
      @(posedge clk_i);
      per_get_i <= 1'b0;
      rd_req <= 1'b0;
   endtask

   // polled at the falling edge so the flag has settled; clears it after
   // the first poll waits a half cycle so a clear in flight is not missed
   task automatic wait_flag(output int t);
      int n;
      n = 0;
      @(negedge clk_i);
      while (timer_match_flag_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
      end
      t = cyc;
      rf_wr(`IRC_RF_MATCH_FLAG, 4'h0);
      @(negedge clk_i);
      chk("flag cleared", {15'h0000, timer_match_flag_o}, 16'h0000);
   endtask

   task automatic pin_hold(input logic lvl);
      repeat (20) @(posedge clk_i);
      repeat (8) begin
         @(negedge clk_i);
         chk("pin level", {15'h0000, ir_carrier_pin_o}, {15'h0000, lvl});
      end
   endtask

   // =====================================================
   // watchdog, generous against the few thousand cycles expected
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      summarize();
   end

   // =====================================================
   // main sequence
   initial begin
      void'($urandom(32'hA7F967BF));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(0, `IRC_RF_TMR_CTL, 8'h00, "ctl reset");
      rd(0, `IRC_RF_MATCH_FLAG, 8'h00, "flag reset");
      rd(0, `IRC_RF_GATE_NEXT, 8'h00, "gate next reset");
      rd(0, `IRC_RF_GATE_LIVE, 8'h00, "gate live reset");
      rd(1, 7'(`IRC_PER_LOW), 8'h00, "low reset");
      rd(1, 7'(`IRC_PER_HIGH), 8'h00, "high reset");
      // clear bit never reads back
      rf_wr(`IRC_RF_TMR_CTL, 4'b1101);
      rd(0, `IRC_RF_TMR_CTL, 8'h0D & 8'h0B, "ctl rw");
      @(posedge clk_i);
      stop_mode_i <= 1'b1;
      @(posedge clk_i);
      stop_mode_i <= 1'b0;
      rd(0, `IRC_RF_TMR_CTL, 8'h01, "ctl after stop");
      rf_wr(`IRC_RF_TMR_CTL, 4'b1001);
      rd(0, `IRC_RF_TMR_CTL, 8'h09, "ctl rerun");
      // unmapped place ignores writes and reads zero
      r1 = 8'h40 + 8'($urandom % 48);
      rf_wr(r1[6:0], 4'hF);
      rd(0, r1[6:0], 8'h00, "unmapped");
      // transfer buffer access kinds, timer stopped and cleared
      rf_wr(`IRC_RF_TMR_CTL, 4'b0100);
      put(`IRC_PER_MATCH, 8'($urandom % 255) + 8'h01);
      rd(1, 7'(`IRC_PER_MATCH), 8'h00, "match unreadable");
      put(`IRC_PER_COUNT, 8'h55);
      rd(1, 7'(`IRC_PER_COUNT), 8'h00, "count not loadable");
      r1 = 8'($urandom);
      r2 = 8'($urandom) & 8'h7F;
      put(`IRC_PER_LOW, r1);
      put(`IRC_PER_HIGH, r2);
      rd(1, 7'(`IRC_PER_LOW), r1, "low rw");
      rd(1, 7'(`IRC_PER_HIGH), r2, "high rw");
      // buffered gate goes live on a match, then carrier shape
      put(`IRC_PER_LOW, 8'h02);
      put(`IRC_PER_HIGH, 8'h01);
      put(`IRC_PER_MATCH, 8'h02);
      rf_wr(`IRC_RF_GATE_NEXT, 4'h1);
      rf_wr(`IRC_RF_TMR_CTL, 4'b1100);
      rf_wr(`IRC_RF_MATCH_FLAG, 4'h0);
      wait_flag(t0);
      rd(0, `IRC_RF_GATE_LIVE, 8'h01, "gate loaded");
      repeat (60) @(posedge clk_i);
      chk("high width", 16'(hi_len), 16'd4);
      chk("low width", 16'(lo_len), 16'd6);
      // match period for every clock select, carrier last
      for (int i = 0; i < 4; i++) begin
         rf_wr(`IRC_RF_TMR_CTL, {2'b11, 2'(i)});
         rf_wr(`IRC_RF_MATCH_FLAG, 4'h0);
         // first flag may straddle the select change; time the next two
         wait_flag(t0);
         wait_flag(t0);
         wait_flag(t1);
         chk("match period", 16'(t1 - t0), 16'(3 * divs[i]));
      end
      // steady level in place of the carrier
      put(`IRC_PER_LOW, 8'h82);
      pin_hold(1'b1);
      // gate closed holds the pin low; timer stopped so no reload
      put(`IRC_PER_LOW, 8'h02);
      // let at least one carrier pulse through before closing the gate
      repeat (12) @(posedge clk_i);
      rf_wr(`IRC_RF_TMR_CTL, 4'b0000);
      rf_wr(`IRC_RF_GATE_NEXT, 4'h0);
      rf_wr(`IRC_RF_GATE_LIVE, 4'h0);
      pin_hold(1'b0);
      // closing mid-pulse must still leave the last high pulse full width
      chk("last pulse", 16'(hi_len), 16'd4);
      repeat (4) @(posedge clk_i);
      summarize();
   end
endmodule

`default_nettype wire

// ---- testbench/irc_led_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// =====================================================
// infrared led driver stand-in: meters on and off run lengths
module irc_led_model (
   input wire logic clk_i,
   input wire logic pin_i,
   output var int hi_len_o,
   output var int lo_len_o
);
   int run_q = 0;
   logic last_q = 1'b0;

   // run-length meter, the led only sees the pin level per system clock
   always_ff @(posedge clk_i) begin
      last_q <= pin_i;
      if (pin_i != last_q) begin
         run_q <= 1;
         if (last_q) begin
            hi_len_o <= run_q;
         end else begin
            lo_len_o <= run_q;
         end
      end else begin
         run_q <= run_q + 1;
      end
   end
endmodule

`default_nettype wire
